// ==== core/pea_accumulator.sv ====
// polyphase total active power and energy accumulation datapath
`timescale 1ns/1ps
`default_nettype none
module pea_accumulator
   import pea_pkg::*;
(
   input  wire logic                     CLK_I,
   input  wire logic                     RESET_I,
   input  wire logic signed [SMP_W-1:0]  VOLT_A_I,
   input  wire logic signed [SMP_W-1:0]  VOLT_B_I,
   input  wire logic signed [SMP_W-1:0]  VOLT_C_I,
   input  wire logic signed [SMP_W-1:0]  CURR_A_I,
   input  wire logic signed [SMP_W-1:0]  CURR_B_I,
   input  wire logic signed [SMP_W-1:0]  CURR_C_I,
   input  wire logic                     HALF_EVENT_EN_I,
   input  wire logic [ADDR_W-1:0]        REG_ADDR_I,
   input  wire logic                     REG_WR_I,
   input  wire logic [REG_W-1:0]         REG_WDATA_I,
   input  wire logic                     REG_RD_I,
   output logic [REG_W-1:0]              REG_RDATA_O,
   output logic                          REG_RVALID_O,
   output logic                          HALF_EVENT_O
);
   // --------------------------------------------------------------
   // register file
   // --------------------------------------------------------------
   function automatic logic phase_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base,
                                      input int p);
      phase_hit = (a == base + ADDR_W'(p));
   endfunction : phase_hit

   logic [7:0]                 div_q;
   logic [7:0]                 cfg_q;
   logic [7:0]                 gcfg_q;
   logic [PULSE_NUM_W-1:0]     pnum_q;
   logic signed [GAIN_W-1:0]   cgain_q [3];
   logic signed [GAIN_W-1:0]   scale_q [3];
   logic signed [GAIN_W-1:0]   ofs_q   [3];
   logic [2:0]                 rev_q;
   logic [REG_W-1:0]           energy_q;
   logic signed [ACC_W-1:0]    acc_q;
   logic signed [ACC_W-1:0]    acc_d;
   pea_phase_type              ph_q;
   logic                       tick;
   logic                       rclr;
   logic [2:0]                 en;
   logic [1:0]                 sel;

   assign tick = (ph_q == PH3);
   assign rclr = REG_RD_I && (REG_ADDR_I == ADDR_ENERGY_RCLR);
   // index 0 is phase A, so the enable field is reversed into phase order
   assign en = {cfg_q[EN_C_BIT], cfg_q[EN_C_BIT+1], cfg_q[EN_A_BIT]};
   assign sel = cfg_q[SEL_HI:SEL_LO];

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         div_q <= 8'h00;
         cfg_q <= POWER_SUM_CFG_RST;
         gcfg_q <= 8'h00;
         pnum_q <= 12'h000;
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == ADDR_ENERGY_DIV) div_q <= REG_WDATA_I[7:0];
         if (REG_ADDR_I == ADDR_POWER_SUM_CFG) cfg_q <= REG_WDATA_I[7:0];
         if (REG_ADDR_I == ADDR_GAIN_CFG) gcfg_q <= REG_WDATA_I[7:0];
         if (REG_ADDR_I == ADDR_PULSE_NUM) pnum_q <= REG_WDATA_I[PULSE_NUM_W-1:0];
      end
   end

   // --------------------------------------------------------------
   // per-phase datapath
   // --------------------------------------------------------------
   logic signed [SMP_W:0]    icor [3];
   logic signed [TERM_W-1:0] term_raw [3];
   logic signed [TERM_W-1:0] term [3];
   logic signed [SMP_W-1:0]  volt [3];
   logic signed [SMP_W-1:0]  curr [3];
   assign volt = '{VOLT_A_I, VOLT_B_I, VOLT_C_I};
   assign curr = '{CURR_A_I, CURR_B_I, CURR_C_I};

   for (genvar p = 0; p < 3; p++) begin : g_phase
      logic signed [SMP_W+1:0]  isel;
      logic signed [47:0]       prod;
      logic signed [47:0]       pofs;
      logic signed [47:0]       pscl;
      logic [TERM_W-1:0]        mag;
      logic signed [SMP_W+GAIN_W-1:0] ig;
      logic signed [47:0]       ps;

      always_ff @(posedge CLK_I) begin
         if (RESET_I) begin
            cgain_q[p] <= 12'h000;
            scale_q[p] <= 12'h000;
            ofs_q[p] <= 12'h000;
         end else if (REG_WR_I) begin
            if (phase_hit(REG_ADDR_I, ADDR_CUR_GAIN, p)) cgain_q[p] <= REG_WDATA_I[11:0];
            if (phase_hit(REG_ADDR_I, ADDR_PWR_SCALE, p)) scale_q[p] <= REG_WDATA_I[11:0];
            if (phase_hit(REG_ADDR_I, ADDR_PWR_OFS, p)) ofs_q[p] <= REG_WDATA_I[11:0];
         end
      end

      // input current is taken as already high-pass filtered
      assign ig = curr[p] * cgain_q[p];
      assign icor[p] = curr[p] + (SMP_W+1)'(ig >>> GAIN_SHIFT);

      always_comb begin
         isel = (SMP_W+2)'(icor[p]);
         if (p == 0 && sel != 2'b00) isel = icor[0] - icor[1];
         if (p == 1 && sel != 2'b00) isel = '0;
         if (p == 2 && sel == 2'b01) isel = icor[2] - icor[1];
      end

      assign prod = 48'(volt[p] * isel) >>> PROD_SHIFT;
      assign pofs = prod + 48'(ofs_q[p]);
      assign ps = pofs * 48'(scale_q[p]);
      assign pscl = pofs + (ps >>> GAIN_SHIFT);
      // middle term is a plain zero outside formula 0, its offset included
      assign term_raw[p] = (en[p] && (p != 1 || sel == 2'b00)) ? TERM_W'(pscl) : '0;
      assign mag = term_raw[p][TERM_W-1] ? TERM_W'(-term_raw[p]) : term_raw[p];

      always_comb begin
         term[p] = term_raw[p];
         if (!gcfg_q[NOLOAD_OFF_BIT] && mag < NO_LOAD_LIMIT) term[p] = '0;
         else if (gcfg_q[ABS_BIT]) term[p] = mag;
      end

      always_ff @(posedge CLK_I) begin
         if (RESET_I) rev_q[p] <= 1'b0;
         else if (tick) rev_q[p] <= en[p] && term_raw[p][TERM_W-1];
      end
   end

   // --------------------------------------------------------------
   // accumulation and division
   // --------------------------------------------------------------
   logic signed [ACC_W-1:0] sum;
   logic signed [ACC_W-1:0] quot;
   logic [REG_W-1:0]        energy_d;
   logic                    half_q;
   logic                    half_d;

   assign sum = ACC_W'(term[0]) + ACC_W'(term[1]) + ACC_W'(term[2]);

   always_ff @(posedge CLK_I) begin
      if (RESET_I) ph_q <= PH0;
      else begin
         case (ph_q)
            PH0: ph_q <= PH1;
            PH1: ph_q <= PH2;
            PH2: ph_q <= PH3;
            PH3: ph_q <= PH0;
            default: ph_q <= PH0;
         endcase
      end
   end

   // clear and the same-cycle sample both land, so no power is lost
   always_comb begin
      acc_d = rclr ? '0 : acc_q;
      if (tick) acc_d = acc_d + sum;
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) acc_q <= '0;
      else acc_q <= acc_d; // two's complement wrap covers both roll-overs
   end

   assign quot = acc_q / $signed({46'h0, (div_q == 8'h00) ? 8'h01 : div_q});
   assign energy_d = quot[ACC_W-1:ENERGY_LSB];
   assign half_d = energy_d[REG_W-1] ^ energy_d[REG_W-2];

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         energy_q <= '0;
         half_q <= 1'b0;
         HALF_EVENT_O <= 1'b0;
      end else begin
         energy_q <= energy_d;
         half_q <= half_d;
         HALF_EVENT_O <= HALF_EVENT_EN_I && half_d && !half_q;
      end
   end

   // --------------------------------------------------------------
   // read port
   // --------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         REG_RDATA_O <= '0;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RVALID_O <= REG_RD_I;
         REG_RDATA_O <= '0;
         if (REG_RD_I) begin
            case (REG_ADDR_I)
               ADDR_ENERGY_VIEW,
               ADDR_ENERGY_RCLR: REG_RDATA_O <= energy_q;
               ADDR_ENERGY_DIV: REG_RDATA_O <= {16'h0000, div_q};
               ADDR_POWER_SUM_CFG: REG_RDATA_O <= {16'h0000, cfg_q};
               ADDR_GAIN_CFG: REG_RDATA_O <= {16'h0000, gcfg_q};
               ADDR_PULSE_NUM: REG_RDATA_O <= {9'h000, rev_q, pnum_q};
               default: begin
                  for (int p = 0; p < 3; p++) begin
                     if (phase_hit(REG_ADDR_I, ADDR_CUR_GAIN, p))
                        REG_RDATA_O <= {12'h000, cgain_q[p]};
                     if (phase_hit(REG_ADDR_I, ADDR_PWR_SCALE, p))
                        REG_RDATA_O <= {12'h000, scale_q[p]};
                     if (phase_hit(REG_ADDR_I, ADDR_PWR_OFS, p))
                        REG_RDATA_O <= {12'h000, ofs_q[p]};
                  end
               end
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   sequence quiet_three;
      !tick [*3];
   endsequence

   tick_period_a: assert property (tick |=> quiet_three ##1 tick)
      else $error("accumulation tick not every four clocks");
   flag_off_a: assert property (tick && !en[0] |=> !rev_q[0])
      else $error("disabled phase shows reverse flag");
   flag_sign_a: assert property (tick && en[2]
                                 |=> rev_q[2] == $past(term_raw[2][TERM_W-1]))
      else $error("reverse flag does not follow power sign");
   flag_hold_a: assert property (!tick |=> $stable(rev_q))
      else $error("reverse flags changed between accumulations");
   clear_read_a: assert property (rclr && !tick |=> acc_q == 0)
      else $error("read-clear did not zero accumulator");
   view_read_a: assert property (REG_RD_I && REG_ADDR_I == ADDR_ENERGY_VIEW && !tick
                                 |=> $stable(acc_q))
      else $error("plain energy read altered accumulator");
   signed_add_a: assert property (tick && !rclr |=> acc_q == $past(acc_q) + $past(sum))
      else $error("accumulation is not a signed add");
   flag_map_a: assert property (REG_RD_I && REG_ADDR_I == ADDR_PULSE_NUM
                                |=> REG_RDATA_O[14:12] == $past(rev_q))
      else $error("reverse flags not at bits 12 to 14");
   half_event_a: assert property (HALF_EVENT_O |-> $past(HALF_EVENT_EN_I) && half_q)
      else $error("half-full event without cause");
   div_zero_a: assert property (div_q == 8'h00
                                |=> energy_q == $past(acc_q[ACC_W-1:ENERGY_LSB]))
      else $error("zero divider not taken as one");

   // --------------------------------------------------------------
   // datapath checks
   // --------------------------------------------------------------
   acc_hold_a: assert property (!tick && !rclr |=> $stable(acc_q))
      else $error("accumulator moved between samples");
   clear_tick_a: assert property (rclr && tick |=> acc_q == $past(sum))
      else $error("read-clear lost the coinciding sample");
   energy_lag_a: assert property ($stable(acc_q) && $stable(div_q)
                                  |=> $stable(energy_q))
      else $error("energy changed with no accumulator change");
   flag_a_sign_a: assert property (tick && en[0]
                                   |=> rev_q[0] == $past(term_raw[0][TERM_W-1]))
      else $error("phase A reverse flag does not follow power sign");
   flag_b_off_a: assert property (tick && !en[1] |=> !rev_q[1])
      else $error("disabled phase B shows reverse flag");
   flag_c_off_a: assert property (tick && !en[2] |=> !rev_q[2])
      else $error("disabled phase C shows reverse flag");

   // term selection and correction, all in the same cycle
   term_off_a: assert property (!en[1] |-> term_raw[1] == '0)
      else $error("disabled phase B term not zero");
   formula_b_a: assert property (sel != 2'b00 |-> term_raw[1] == '0)
      else $error("middle term not zero outside formula 0");
   formula_a_a: assert property (sel != 2'b00
                                 |-> g_phase[0].isel == icor[0] - icor[1])
      else $error("phase A current not the A minus B difference");
   formula_c_a: assert property (sel == 2'b01
                                 |-> g_phase[2].isel == icor[2] - icor[1])
      else $error("phase C current not the C minus B difference");
   formula_c2_a: assert property (sel[1] |-> g_phase[2].isel == icor[2])
      else $error("phase C current not taken alone");
   unity_gain_a: assert property (cgain_q[0] == '0 |-> icor[0] == CURR_A_I)
      else $error("zero current gain altered the sample");
   unity_scale_a: assert property (scale_q[2] == '0
                                   |-> g_phase[2].pscl == g_phase[2].pofs)
      else $error("zero power scale altered the term");
   noload_a: assert property (!gcfg_q[NOLOAD_OFF_BIT] && g_phase[1].mag < NO_LOAD_LIMIT
                              |-> term[1] == '0)
      else $error("power below no-load limit was accumulated");
   abs_term_a: assert property (gcfg_q[ABS_BIT] && g_phase[0].mag >= NO_LOAD_LIMIT
                                |-> term[0] == g_phase[0].mag)
      else $error("absolute mode term not the magnitude");
   plain_term_a: assert property (!gcfg_q[ABS_BIT] && g_phase[2].mag >= NO_LOAD_LIMIT
                                  |-> term[2] == term_raw[2])
      else $error("arithmetic mode term altered");

   // event checks
   half_gate_a: assert property (!HALF_EVENT_EN_I |=> !HALF_EVENT_O)
      else $error("half-full event while disabled");
   half_level_a: assert property (HALF_EVENT_O
                                  |-> energy_q[REG_W-1] != energy_q[REG_W-2])
      else $error("half-full event outside half-full region");
endmodule : pea_accumulator
`default_nettype wire

// ==== core/pea_pkg.sv ====
// constants and types of the polyphase energy accumulator
`default_nettype none
package pea_pkg;
   localparam int SMP_W = 16;
   localparam int GAIN_W = 12;
   localparam int ACC_W = 54;
   localparam int TERM_W = 32;
   localparam int REG_W = 24;
   localparam int ADDR_W = 8;
   localparam int GAIN_SHIFT = 12;
   localparam int PROD_SHIFT = 6;
   localparam int ENERGY_LSB = ACC_W - REG_W;
   localparam logic [ADDR_W-1:0] ADDR_ENERGY_VIEW = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_ENERGY_RCLR = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_ENERGY_DIV = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_POWER_SUM_CFG = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_PULSE_NUM = 8'h06;
   localparam logic [ADDR_W-1:0] ADDR_CUR_GAIN = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_PWR_SCALE = 8'h0B;
   localparam logic [ADDR_W-1:0] ADDR_PWR_OFS = 8'h0E;
   localparam logic [ADDR_W-1:0] ADDR_GAIN_CFG = 8'h18;
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam int EN_A_BIT = 5;
   localparam int EN_C_BIT = 3;
   localparam int ABS_BIT = 2;
   localparam int NOLOAD_OFF_BIT = 3;
   localparam int REV_A_BIT = 12;
   localparam int PULSE_NUM_W = 12;
   localparam logic [7:0] POWER_SUM_CFG_RST = 8'h38;
   localparam logic [TERM_W-1:0] NO_LOAD_LIMIT = 32'h0000_02AF;
   typedef enum logic [1:0] {
      PH0 = 2'b00,
      PH1 = 2'b01,
      PH2 = 2'b11,
      PH3 = 2'b10
   } pea_phase_type;
endpackage : pea_pkg
`default_nettype wire

// ==== verification/pea_host_model.sv ====
// host-side register access model for the energy accumulator
`timescale 1ns/1ps
`default_nettype none
module pea_host_model
   import pea_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic [REG_W-1:0]  rdata_i,
   input  wire logic              rvalid_i,
   output logic [ADDR_W-1:0]      addr_o,
   output logic                   wr_o,
   output logic                   rd_o,
   output logic [REG_W-1:0]       wdata_o
);
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 24'h000000;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d, output bit ok);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      ok = (rvalid_i === 1'b1);
      d = rdata_i;
   endtask : rd
endmodule : pea_host_model
`default_nettype wire

// ==== verification/tb_polyphase_energy_accumulator.sv ====
// self-checking bench for the polyphase energy accumulator
`timescale 1ns/1ps
`default_nettype none
module tb_polyphase_energy_accumulator
   import pea_pkg::*;
;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    half_en = 1'b1;
   logic signed [SMP_W-1:0] volt = 16'h0000;
   logic signed [SMP_W-1:0] cur_a = 16'h0000;
   logic signed [SMP_W-1:0] cur_b = 16'h0000;
   logic signed [SMP_W-1:0] cur_c = 16'h0000;
   logic [ADDR_W-1:0]       addr;
   logic                    wr;
   logic                    rd;
   logic                    rvalid;
   logic [REG_W-1:0]        wdata;
   logic [REG_W-1:0]        rdata;
   logic                    half_evt;
   int                      half_seen = 0;
   int                      mismatches = 0;
   int                      samples_checked = 0;
   logic [7:0]              cfgs [7] = '{8'h38, 8'h28, 8'h18, 8'h78, 8'hB8, 8'hA0, 8'hF8};
   always #2 clk = ~clk;
   // events are counted mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      if (half_evt !== 1'b0) half_seen++;
   end
   pea_accumulator pea_accumulator_i (.CLK_I(clk), .RESET_I(rst), .VOLT_A_I(volt),
      .VOLT_B_I(volt), .VOLT_C_I(volt), .CURR_A_I(cur_a), .CURR_B_I(cur_b), .CURR_C_I(cur_c),
      .HALF_EVENT_EN_I(half_en), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
      .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .HALF_EVENT_O(half_evt));
   pea_host_model pea_host_model_i (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
      .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
      logic [REG_W-1:0] d;
      bit               ok;
      pea_host_model_i.rd(a, d, ok);
      chk({23'h000000, ok}, 24'h000001);
      chk(d, exp);
   endtask : rchk
   task automatic set_smp(input logic signed [SMP_W-1:0] a, b, c);
      @(posedge clk);
      #1;
      volt = 16'h7FFF;
      cur_a = a;
      cur_b = b;
      cur_c = c;
   endtask : set_smp
   // total of enabled terms; sa is the phase A scale gain
   function automatic longint tsum(logic [7:0] cfg, longint ia, ib, ic, sa);
      longint v;
      longint ta;
      v = 32767;
      ta = (v * (cfg[7:6] == 2'b00 ? ia : ia - ib)) >>> 6;
      ta = ta + ((ta * sa) >>> 12);
      return (cfg[5] ? ta : 0) + (cfg[4] && cfg[7:6] == 2'b00 ? (v * ib) >>> 6 : 0)
         + (cfg[3] ? (v * (cfg[7:6] == 2'b01 ? ic - ib : ic)) >>> 6 : 0);
   endfunction : tsum
   // window of 4k edges holds exactly k ticks whatever the tick phase
   task automatic etest(input logic [7:0] cfg, input logic [7:0] div, input int k,
      input logic signed [SMP_W-1:0] a, b, c, input longint sa, output logic [REG_W-1:0] e);
      logic [REG_W-1:0] d;
      bit               ok;
      longint           acc;
      pea_host_model_i.wr(ADDR_POWER_SUM_CFG, {16'h0000, cfg});
      pea_host_model_i.wr(ADDR_ENERGY_DIV, {16'h0000, div});
      pea_host_model_i.rd(ADDR_ENERGY_RCLR, d, ok);
      set_smp(a, b, c);
      repeat (4 * k) @(posedge clk);
      #1;
      volt = 16'h0000;
      cur_a = 16'h0000;
      cur_b = 16'h0000;
      cur_c = 16'h0000;
      repeat (8) @(posedge clk);
      acc = k * tsum(cfg, a, b, c, sa);
      if (div != 8'h00) begin
         acc = acc / longint'(div);
      end
      e = acc[53:30];
   endtask : etest
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [REG_W-1:0] e;
      longint           p;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      rchk(ADDR_POWER_SUM_CFG, 24'h000038);
      rchk(ADDR_PULSE_NUM, 24'h000000);
      rchk(8'h01, 24'h000000);
      rchk(ADDR_ENERGY_DIV, 24'h000000);
      pea_host_model_i.wr(ADDR_ENERGY_DIV, 24'h1234A5);
      rchk(ADDR_ENERGY_DIV, 24'h0000A5);
      $display("test defaults done");
      // current gains stay at default, trimming goes through scale gains
      foreach (cfgs[n]) begin
         etest(cfgs[n], 8'h00, 300, 16'h7FFF, 16'h4000, 16'h7FFF, 0, e);
         rchk(ADDR_ENERGY_VIEW, e);
      end
      rchk(ADDR_ENERGY_VIEW, e);
      rchk(ADDR_ENERGY_RCLR, e);
      rchk(ADDR_ENERGY_VIEW, 24'h000000);
      $display("test formulas done");
      etest(8'h38, 8'h00, 300, 16'h8001, 16'h8001, 16'h8001, 0, e);
      rchk(ADDR_ENERGY_VIEW, e);
      pea_host_model_i.wr(ADDR_GAIN_CFG, 24'h000004);
      etest(8'h38, 8'h00, 300, 16'h8001, 16'h8001, 16'h8001, 0, e);
      p = -300 * tsum(8'h38, -32767, -32767, -32767, 0);
      rchk(ADDR_ENERGY_VIEW, p[53:30]);
      pea_host_model_i.wr(ADDR_GAIN_CFG, 24'h000000);
      etest(8'h38, 8'h03, 300, 16'h7FFF, 16'h4000, 16'h7FFF, 0, e);
      rchk(ADDR_ENERGY_VIEW, e);
      pea_host_model_i.wr(ADDR_PWR_SCALE, 24'h000800);
      etest(8'h20, 8'h00, 300, 16'h7FFF, 16'h4000, 16'h7FFF, -2048, e);
      rchk(ADDR_ENERGY_VIEW, e);
      pea_host_model_i.wr(ADDR_PWR_SCALE, 24'h000000);
      $display("test energy done");
      set_smp(16'h8001, 16'h7FFF, 16'h8001);
      half_en = 1'b0;
      pea_host_model_i.wr(ADDR_POWER_SUM_CFG, 24'h000038);
      pea_host_model_i.wr(ADDR_PULSE_NUM, 24'hFFFFFF);
      repeat (8) @(posedge clk);
      rchk(ADDR_PULSE_NUM, 24'h005FFF);
      pea_host_model_i.wr(ADDR_POWER_SUM_CFG, 24'h000018);
      repeat (8) @(posedge clk);
      rchk(ADDR_PULSE_NUM, 24'h004FFF);
      set_smp(16'h8001, 16'h8001, 16'h8001);
      pea_host_model_i.wr(ADDR_POWER_SUM_CFG, 24'h000038);
      repeat (8) @(posedge clk);
      rchk(ADDR_PULSE_NUM, 24'h007FFF);
      set_smp(16'h7FFF, 16'h7FFF, 16'h7FFF);
      repeat (8) @(posedge clk);
      rchk(ADDR_PULSE_NUM, 24'h000FFF);
      chk(24'(half_seen), 24'h000000);
      $display("test reverse flags done");
      results();
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule : tb_polyphase_energy_accumulator
`default_nettype wire
